// ===== hw/pbt_pkg.sv
/*
 Constants and types for the configuration memory test access port.
 Assumes the system clock runs at 125 MHz and the test clock is external.
*/
package pbt_pkg;
	localparam int IR_LEN = 8;
	localparam logic [7:0] OP_EXTEST = 8'h00;
	localparam logic [7:0] OP_SAMPLE = 8'h01;
	localparam logic [7:0] OP_CLAMP = 8'hFA;
	localparam logic [7:0] OP_HIGHZ = 8'hFC;
	localparam logic [7:0] OP_IDENTIFICATION_REGISTER = 8'hFE;
	localparam logic [7:0] OP_USER_CODE_REGISTER = 8'hFD;
	localparam logic [7:0] OP_BYPASS = 8'hFF;
	localparam logic [7:0] OP_RELOAD = 8'hEE;
	localparam logic [7:0] IR_CAPTURE_FIXED = 8'h01;
	localparam int IR_PROG_STATUS_POS = 4;
	localparam int IR_SECURITY_POS = 3;
	localparam int N_OUT = 9;
	localparam int N_IN = 3;
	localparam int BSR_LEN = 2 * N_OUT + N_IN;
	localparam int WORD_LEN = 32;
	// Identity fields: values are arbitrary
	localparam logic [3:0] ID_VERSION = 4'h1;
	localparam logic [7:0] ID_FAMILY = 8'hA5;
	localparam logic [7:0] ID_PRODUCT = 8'h3C;
	localparam logic [10:0] ID_MAKER = 11'h2B5;
	localparam logic ID_LSB = 1'b1;
	localparam logic [31:0] ID_WORD = {ID_VERSION, ID_FAMILY, ID_PRODUCT,
		ID_MAKER, ID_LSB};
	localparam logic [31:0] USER_CODE_REGISTER_BLANK = 32'hFFFFFFFF;
	localparam int CLK_PERIOD_NS = 8;
	localparam int RELOAD_MIN_NS = 300;
	localparam int RELOAD_MAX_NS = 500;
	localparam int RELOAD_CYCLES =
		(RELOAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RELOAD_CNT_W = 6;

	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
		ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
		ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} pbt_tap_state_type;

	typedef enum logic [1:0] {
		DR_BYPASS, DR_WORD, DR_BSR
	} pbt_dr_sel_type;
endpackage

// ===== hw/pbt_reload_if.sv
/*
 Carrier between the test clock logic and the reload pulse timer.
 Assumes the toggle is only read through a synchroniser.
*/
`timescale 1ns/10ps
interface pbt_reload_if;
	logic req_toggle;
	logic pulse_n;
	modport tap (output req_toggle, input pulse_n);
	modport pulser (input req_toggle, output pulse_n);
endinterface

// ===== hw/pbt_reload_pulser.sv
/*
 Reload pulse timer on the system clock.
 Assumes each request is a toggle made on the test clock.
*/
`timescale 1ns/10ps
module pbt_reload_pulser (
	input wire logic clk_in,
	input wire logic rst_in,
	pbt_reload_if.pulser rl
);
	logic sync1_reg;
	logic sync2_reg;
	logic seen_reg;
	logic [pbt_pkg::RELOAD_CNT_W-1:0] cnt_reg;
	logic active_reg;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			seen_reg <= 1'b0;
		end else begin
			sync1_reg <= rl.req_toggle;
			sync2_reg <= sync1_reg;
			seen_reg <= sync2_reg;
		end
	end

	// Counted at the minimum so the pulse stays inside the window
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_reg <= '0;
			active_reg <= 1'b0;
		end else if (sync2_reg != seen_reg) begin
			cnt_reg <= pbt_pkg::RELOAD_CNT_W'(pbt_pkg::RELOAD_CYCLES - 1);
			active_reg <= 1'b1;
		end else if (cnt_reg != '0) begin
			cnt_reg <= cnt_reg - 1'b1;
		end else begin
			active_reg <= 1'b0;
		end
	end

	assign rl.pulse_n = ~active_reg;
endmodule // pbt_reload_pulser

// ===== hw/pbt_tap.sv
/*
 Boundary-scan test access port of a reprogrammable configuration memory.
 Assumes test pins are on the test clock; core signals on the system clock.
*/
`timescale 1ns/10ps
module pbt_tap (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdi_in,
	output logic tdo_out,
	output logic tdo_oe_out,
	input wire logic [pbt_pkg::N_OUT-1:0] func_out_in,
	input wire logic [pbt_pkg::N_OUT-1:0] func_oe_in,
	output logic [pbt_pkg::N_OUT-1:0] pin_out,
	output logic [pbt_pkg::N_OUT-1:0] pin_oe_out,
	input wire logic [pbt_pkg::N_IN-1:0] pin_in,
	input wire logic in_system_program_mode_in,
	input wire logic security_set_in,
	input wire logic erase_all_in,
	input wire logic user_code_register_load_in,
	input wire logic [31:0] user_code_register_value_in,
	output logic read_allow_out,
	output logic program_allow_out,
	output logic target_reload_pulse_n_out
);
	function automatic pbt_pkg::pbt_dr_sel_type dr_sel(input logic [7:0] op);
		unique case (op)
			pbt_pkg::OP_EXTEST,
			pbt_pkg::OP_SAMPLE: dr_sel = pbt_pkg::DR_BSR;
			pbt_pkg::OP_IDENTIFICATION_REGISTER,
			pbt_pkg::OP_USER_CODE_REGISTER: dr_sel = pbt_pkg::DR_WORD;
			default: dr_sel = pbt_pkg::DR_BYPASS;
		endcase
	endfunction

	// Cell nearer the serial input holds the value, the next the enable
	function automatic int val_idx(input int k);
		val_idx = pbt_pkg::BSR_LEN - 1 - 2 * k;
	endfunction

	function automatic int en_idx(input int k);
		en_idx = pbt_pkg::BSR_LEN - 2 - 2 * k;
	endfunction

	pbt_reload_if rl ();

	pbt_reload_pulser u_pulser (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.rl(rl)
	);

	assign target_reload_pulse_n_out = rl.pulse_n;

	// System clock side: security and user code storage
	logic security_reg;
	logic [31:0] user_code_register_reg;
	logic uc_toggle_reg;

	// Set beats a same-cycle erase so a protection request is never lost
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			security_reg <= 1'b0;
		end else if (security_set_in) begin
			security_reg <= 1'b1;
		end else if (erase_all_in) begin
			security_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			user_code_register_reg <= pbt_pkg::USER_CODE_REGISTER_BLANK;
			uc_toggle_reg <= 1'b0;
		end else if (erase_all_in) begin
			user_code_register_reg <= pbt_pkg::USER_CODE_REGISTER_BLANK;
			uc_toggle_reg <= ~uc_toggle_reg;
		end else if (user_code_register_load_in && !security_reg) begin
			user_code_register_reg <= user_code_register_value_in;
			uc_toggle_reg <= ~uc_toggle_reg;
		end
	end

	assign read_allow_out = ~security_reg;
	assign program_allow_out = ~security_reg;

	// Test clock side: reset and level synchronisers
	logic rst_s1_reg;
	logic tck_rst;
	logic isp_s1_reg;
	logic isp_t;
	logic sec_s1_reg;
	logic sec_t;
	logic uct_s1_reg;
	logic uct_s2_reg;
	logic uct_seen_reg;
	logic [31:0] uc_tck_reg;
	logic [pbt_pkg::N_IN-1:0] pin_s1_reg;
	logic [pbt_pkg::N_IN-1:0] pin_t;

	always_ff @(posedge tck_in) begin
		rst_s1_reg <= rst_in;
		tck_rst <= rst_s1_reg;
	end

	always_ff @(posedge tck_in) begin
		if (tck_rst) begin
			isp_s1_reg <= 1'b0;
			isp_t <= 1'b0;
			sec_s1_reg <= 1'b0;
			sec_t <= 1'b0;
			pin_s1_reg <= '0;
			pin_t <= '0;
		end else begin
			isp_s1_reg <= in_system_program_mode_in;
			isp_t <= isp_s1_reg;
			sec_s1_reg <= security_reg;
			sec_t <= sec_s1_reg;
			pin_s1_reg <= pin_in;
			pin_t <= pin_s1_reg;
		end
	end

	// User code word is stable long before its toggle arrives here
	always_ff @(posedge tck_in) begin
		if (tck_rst) begin
			uct_s1_reg <= 1'b0;
			uct_s2_reg <= 1'b0;
			uct_seen_reg <= 1'b0;
			uc_tck_reg <= pbt_pkg::USER_CODE_REGISTER_BLANK;
		end else begin
			uct_s1_reg <= uc_toggle_reg;
			uct_s2_reg <= uct_s1_reg;
			uct_seen_reg <= uct_s2_reg;
			if (uct_s2_reg != uct_seen_reg) begin
				uc_tck_reg <= user_code_register_reg;
			end
		end
	end

	// Controller
	pbt_pkg::pbt_tap_state_type state_reg;
	pbt_pkg::pbt_tap_state_type state_next;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			pbt_pkg::ST_RESET:
				state_next = tms_in ? pbt_pkg::ST_RESET : pbt_pkg::ST_IDLE;
			pbt_pkg::ST_IDLE:
				state_next = tms_in ? pbt_pkg::ST_SEL_DR : pbt_pkg::ST_IDLE;
			pbt_pkg::ST_SEL_DR:
				state_next = tms_in ? pbt_pkg::ST_SEL_IR : pbt_pkg::ST_CAP_DR;
			pbt_pkg::ST_CAP_DR:
				state_next = tms_in ? pbt_pkg::ST_EXIT1_DR : pbt_pkg::ST_SHIFT_DR;
			pbt_pkg::ST_SHIFT_DR:
				state_next = tms_in ? pbt_pkg::ST_EXIT1_DR : pbt_pkg::ST_SHIFT_DR;
			pbt_pkg::ST_EXIT1_DR:
				state_next = tms_in ? pbt_pkg::ST_UPD_DR : pbt_pkg::ST_PAUSE_DR;
			pbt_pkg::ST_PAUSE_DR:
				state_next = tms_in ? pbt_pkg::ST_EXIT2_DR : pbt_pkg::ST_PAUSE_DR;
			pbt_pkg::ST_EXIT2_DR:
				state_next = tms_in ? pbt_pkg::ST_UPD_DR : pbt_pkg::ST_SHIFT_DR;
			pbt_pkg::ST_UPD_DR:
				state_next = tms_in ? pbt_pkg::ST_SEL_DR : pbt_pkg::ST_IDLE;
			pbt_pkg::ST_SEL_IR:
				state_next = tms_in ? pbt_pkg::ST_RESET : pbt_pkg::ST_CAP_IR;
			pbt_pkg::ST_CAP_IR:
				state_next = tms_in ? pbt_pkg::ST_EXIT1_IR : pbt_pkg::ST_SHIFT_IR;
			pbt_pkg::ST_SHIFT_IR:
				state_next = tms_in ? pbt_pkg::ST_EXIT1_IR : pbt_pkg::ST_SHIFT_IR;
			pbt_pkg::ST_EXIT1_IR:
				state_next = tms_in ? pbt_pkg::ST_UPD_IR : pbt_pkg::ST_PAUSE_IR;
			pbt_pkg::ST_PAUSE_IR:
				state_next = tms_in ? pbt_pkg::ST_EXIT2_IR : pbt_pkg::ST_PAUSE_IR;
			pbt_pkg::ST_EXIT2_IR:
				state_next = tms_in ? pbt_pkg::ST_UPD_IR : pbt_pkg::ST_SHIFT_IR;
			pbt_pkg::ST_UPD_IR:
				state_next = tms_in ? pbt_pkg::ST_SEL_DR : pbt_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge tck_in) begin
		if (tck_rst) begin
			state_reg <= pbt_pkg::ST_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Instruction register
	logic [pbt_pkg::IR_LEN-1:0] ir_shift_reg;
	logic [pbt_pkg::IR_LEN-1:0] instruction_register;
	logic reload_tgl_reg;
	logic [pbt_pkg::IR_LEN-1:0] ir_capture;

	always_comb begin
		ir_capture = pbt_pkg::IR_CAPTURE_FIXED;
		ir_capture[pbt_pkg::IR_PROG_STATUS_POS] = isp_t;
		ir_capture[pbt_pkg::IR_SECURITY_POS] = sec_t;
	end

	always_ff @(posedge tck_in) begin
		if (tck_rst) begin
			ir_shift_reg <= '0;
		end else if (state_reg == pbt_pkg::ST_CAP_IR) begin
			ir_shift_reg <= ir_capture;
		end else if (state_reg == pbt_pkg::ST_SHIFT_IR) begin
			ir_shift_reg <= {tdi_in, ir_shift_reg[pbt_pkg::IR_LEN-1:1]};
		end
	end

	// Reset state falls back to the identification word
	always_ff @(posedge tck_in) begin
		if (tck_rst || state_reg == pbt_pkg::ST_RESET) begin
			instruction_register <= pbt_pkg::OP_IDENTIFICATION_REGISTER;
		end else if (state_reg == pbt_pkg::ST_UPD_IR) begin
			instruction_register <= ir_shift_reg;
		end
	end

	always_ff @(posedge tck_in) begin
		if (tck_rst) begin
			reload_tgl_reg <= 1'b0;
		end else if (state_reg == pbt_pkg::ST_UPD_IR &&
			ir_shift_reg == pbt_pkg::OP_RELOAD) begin
			reload_tgl_reg <= ~reload_tgl_reg;
		end
	end

	assign rl.req_toggle = reload_tgl_reg;

	// Data registers
	pbt_pkg::pbt_dr_sel_type sel;
	logic bypass_reg;
	logic [pbt_pkg::WORD_LEN-1:0] word_shift_reg;
	logic [pbt_pkg::BSR_LEN-1:0] bsr_shift_reg;
	logic [pbt_pkg::BSR_LEN-1:0] bsr_upd_reg;
	logic [pbt_pkg::BSR_LEN-1:0] bsr_capture;

	assign sel = dr_sel(instruction_register);

	always_comb begin
		bsr_capture = '0;
		for (int k = 0; k < pbt_pkg::N_OUT; k++) begin
			bsr_capture[val_idx(k)] = pin_out[k];
			bsr_capture[en_idx(k)] = pin_oe_out[k];
		end
		for (int j = 0; j < pbt_pkg::N_IN; j++) begin
			bsr_capture[j] = pin_t[j];
		end
	end

	always_ff @(posedge tck_in) begin
		if (tck_rst) begin
			bypass_reg <= 1'b0;
		end else if (state_reg == pbt_pkg::ST_CAP_DR) begin
			bypass_reg <= 1'b0;
		end else if (state_reg == pbt_pkg::ST_SHIFT_DR) begin
			bypass_reg <= tdi_in;
		end
	end

	always_ff @(posedge tck_in) begin
		if (tck_rst) begin
			word_shift_reg <= '0;
		end else if (state_reg == pbt_pkg::ST_CAP_DR) begin
			if (instruction_register == pbt_pkg::OP_USER_CODE_REGISTER) begin
				word_shift_reg <= uc_tck_reg;
			end else begin
				word_shift_reg <= pbt_pkg::ID_WORD;
			end
		end else if (state_reg == pbt_pkg::ST_SHIFT_DR) begin
			word_shift_reg <= {tdi_in, word_shift_reg[pbt_pkg::WORD_LEN-1:1]};
		end
	end

	always_ff @(posedge tck_in) begin
		if (tck_rst) begin
			bsr_shift_reg <= '0;
		end else if (state_reg == pbt_pkg::ST_CAP_DR && sel == pbt_pkg::DR_BSR) begin
			bsr_shift_reg <= bsr_capture;
		end else if (state_reg == pbt_pkg::ST_SHIFT_DR &&
			sel == pbt_pkg::DR_BSR) begin
			bsr_shift_reg <= {tdi_in, bsr_shift_reg[pbt_pkg::BSR_LEN-1:1]};
		end
	end

	// Update cells are held through clamp so preloaded values survive
	always_ff @(posedge tck_in) begin
		if (tck_rst) begin
			bsr_upd_reg <= '0;
		end else if (state_reg == pbt_pkg::ST_UPD_DR && sel == pbt_pkg::DR_BSR) begin
			bsr_upd_reg <= bsr_shift_reg;
		end
	end

	// Serial output changes on the falling edge for the host's rising sample
	logic tdo_next;
	logic tdo_reg;
	logic tdo_oe_reg;

	always_comb begin
		tdo_next = bypass_reg;
		if (state_reg == pbt_pkg::ST_SHIFT_IR) begin
			tdo_next = ir_shift_reg[0];
		end else begin
			unique case (sel)
				pbt_pkg::DR_WORD: tdo_next = word_shift_reg[0];
				pbt_pkg::DR_BSR: tdo_next = bsr_shift_reg[0];
				pbt_pkg::DR_BYPASS: tdo_next = bypass_reg;
			endcase
		end
	end

	always_ff @(negedge tck_in) begin
		if (tck_rst) begin
			tdo_reg <= 1'b0;
			tdo_oe_reg <= 1'b0;
		end else begin
			tdo_reg <= tdo_next;
			tdo_oe_reg <= (state_reg == pbt_pkg::ST_SHIFT_IR) ||
				(state_reg == pbt_pkg::ST_SHIFT_DR);
		end
	end

	assign tdo_out = tdo_reg;
	assign tdo_oe_out = tdo_oe_reg;

	// Pin drive
	logic bsr_drive;
	logic all_float;

	assign bsr_drive = (instruction_register == pbt_pkg::OP_EXTEST) ||
		(instruction_register == pbt_pkg::OP_CLAMP);
	assign all_float = (instruction_register == pbt_pkg::OP_HIGHZ);

	// Programming mode acts at once from the system side, not via the sync
	always_comb begin
		for (int k = 0; k < pbt_pkg::N_OUT; k++) begin
			if (bsr_drive) begin
				pin_out[k] = bsr_upd_reg[val_idx(k)];
				pin_oe_out[k] = bsr_upd_reg[en_idx(k)];
			end else begin
				pin_out[k] = func_out_in[k];
				pin_oe_out[k] = func_oe_in[k] && !in_system_program_mode_in;
			end
			if (all_float) begin
				pin_oe_out[k] = 1'b0;
			end
		end
	end
endmodule // pbt_tap

// ===== dv/pbt_host.sv
/*
 Host model for the test access port: drives test clock, mode and data in.
 Assumes the port samples mode and data on the rising test clock edge.
*/
`timescale 1ns/10ps
module pbt_host (
	output logic tck_out,
	output logic tms_out,
	output logic tdi_out,
	input wire logic tdo_in
);
	// Pulled-up lines idle high, clock stands low outside frames
	initial begin
		tck_out = 1'b0;
		tms_out = 1'b1;
		tdi_out = 1'b1;
	end

	task automatic tick(input logic m, input logic d, output logic o);
		tms_out = m;
		tdi_out = d;
		#32;
		o = tdo_in;
		tck_out = 1'b1;
		#32;
		tck_out = 1'b0;
	endtask

	task automatic reset_tap();
		logic o;
		#3;
		repeat (6) tick(1'b1, 1'b1, o);
		tick(1'b0, 1'b1, o);
	endtask

	// Starts and ends in Idle; bits go LSB first
	task automatic scan(input logic instr, input int n,
		input logic [31:0] din, output logic [31:0] dout);
		logic o;
		#3;
		tick(1'b1, 1'b1, o);
		if (instr) tick(1'b1, 1'b1, o);
		tick(1'b0, 1'b1, o);
		tick(1'b0, 1'b1, o);
		dout = 32'h0;
		for (int i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], o);
			dout[i] = o;
		end
		tick(1'b1, 1'b1, o);
		tick(1'b0, 1'b1, o);
	endtask
endmodule // pbt_host

// ===== dv/pbt_tap_props.sv
/*
 Checker for the test access port top.
 Assumes it sees only the top ports; bound below.
*/
`timescale 1ns/10ps
module pbt_tap_props (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic tck_in,
	input wire logic tms_in,
	input wire logic tdo_oe_out,
	input wire logic security_set_in,
	input wire logic erase_all_in,
	input wire logic read_allow_out,
	input wire logic program_allow_out,
	input wire logic target_reload_pulse_n_out
);
	// Saturates so a stuck pulse cannot wrap back into range
	logic [7:0] low_cnt_reg;
	always_ff @(posedge clk_in) begin
		if (rst_in || target_reload_pulse_n_out)
			low_cnt_reg <= 8'h00;
		else if (low_cnt_reg != 8'hFF)
			low_cnt_reg <= low_cnt_reg + 8'h01;
	end

	sequence s_pulse_start;
		$fell(target_reload_pulse_n_out);
	endsequence
	sequence s_pulse_hold;
		!target_reload_pulse_n_out [*8];
	endsequence
	property p_reload_min;
		@(posedge clk_in) disable iff (rst_in) s_pulse_start |-> s_pulse_hold;
	endproperty
	a_reload_min: assert property (p_reload_min)
		else $error("reload pulse ended early");
	property p_reload_width;
		@(posedge clk_in) disable iff (rst_in) $rose(target_reload_pulse_n_out)
			|-> low_cnt_reg >= 8'h26 && low_cnt_reg <= 8'h3E;
	endproperty
	a_reload_width: assert property (p_reload_width)
		else $error("reload pulse width out of range");
	property p_sec_lock;
		@(posedge clk_in) disable iff (rst_in) security_set_in
			|=> !read_allow_out && !program_allow_out;
	endproperty
	a_sec_lock: assert property (p_sec_lock)
		else $error("security set did not block access");
	property p_erase_clear;
		@(posedge clk_in) disable iff (rst_in) erase_all_in && !security_set_in
			|=> read_allow_out && program_allow_out;
	endproperty
	a_erase_clear: assert property (p_erase_clear)
		else $error("erase did not clear security");
	property p_sec_hold;
		@(posedge clk_in) disable iff (rst_in)
			!read_allow_out && !erase_all_in |=> !read_allow_out;
	endproperty
	a_sec_hold: assert property (p_sec_hold)
		else $error("security cleared without erase");
	property p_no_lock;
		@(posedge clk_in) disable iff (rst_in)
			program_allow_out && !security_set_in |=> program_allow_out;
	endproperty
	a_no_lock: assert property (p_no_lock)
		else $error("programming blocked without security");
	property p_oe_exit;
		@(posedge tck_in) disable iff (rst_in) tdo_oe_out && tms_in
			|=> !tdo_oe_out;
	endproperty
	a_oe_exit: assert property (p_oe_exit)
		else $error("data out enable stayed after shift exit");
	property p_oe_hold;
		@(posedge tck_in) disable iff (rst_in) tdo_oe_out && !tms_in
			|=> tdo_oe_out;
	endproperty
	a_oe_hold: assert property (p_oe_hold)
		else $error("data out enable dropped during shift");
endmodule // pbt_tap_props

bind pbt_tap pbt_tap_props pbt_tap_props_inst (.clk_in, .rst_in, .tck_in,
	.tms_in, .tdo_oe_out, .security_set_in, .erase_all_in, .read_allow_out,
	.program_allow_out, .target_reload_pulse_n_out);

// ===== dv/tb_top.sv
/*
 Testbench for the test access port, driven through the host model.
 Assumes a 125 MHz system clock and a 64 ns test clock from the host.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	mismatches++; $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_top;
	logic clk_in, rst_in, tck, tms, tdi, tdo, prog_mode, sec_set, erase;
	logic uc_load, read_allow, prog_allow, reload_n, tdo_oe, tdo_pin;
	logic [8:0] pin_out, pin_oe_out, fo, foe;
	logic [2:0] pin_in;
	logic [31:0] uc_val, d;
	logic [20:0] bs;
	logic [20:0] pre = 21'h0B5A3C;
	logic [7:0] byp [4] = '{pbt_pkg::OP_CLAMP, pbt_pkg::OP_BYPASS, 8'h5A, 8'h02};
	int mismatches = 0;
	int check_count = 0;
	int low_cnt = 0;
	int last_low = 0;

	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	// Released data out reads its pull-up level at the host
	assign tdo_pin = tdo_oe ? tdo : 1'b1;

	pbt_host pbt_host_inst (.tck_out(tck), .tms_out(tms), .tdi_out(tdi),
		.tdo_in(tdo_pin));
	pbt_tap pbt_tap_inst (.clk_in(clk_in), .rst_in(rst_in), .tck_in(tck),
		.tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
		.func_out_in(fo), .func_oe_in(foe), .pin_out(pin_out),
		.pin_oe_out(pin_oe_out), .pin_in(pin_in),
		.in_system_program_mode_in(prog_mode), .security_set_in(sec_set),
		.erase_all_in(erase), .user_code_register_load_in(uc_load),
		.user_code_register_value_in(uc_val), .read_allow_out(read_allow),
		.program_allow_out(prog_allow), .target_reload_pulse_n_out(reload_n));

	// Width of the last completed reload pulse, in system clocks
	always @(posedge clk_in) begin
		if (!reload_n)
			low_cnt <= low_cnt + 1;
		else begin
			if (low_cnt != 0)
				last_low <= low_cnt;
			low_cnt <= 0;
		end
	end

	function automatic logic [20:0] bsr(input logic [8:0] o,
		input logic [8:0] e, input logic [2:0] i);
		logic [20:0] v;
		v[2:0] = i;
		for (int k = 0; k < pbt_pkg::N_OUT; k++) begin
			v[20 - 2 * k] = o[k];
			v[19 - 2 * k] = e[k];
		end
		return v;
	endfunction

	task automatic instr_scan(input logic [7:0] op, input logic [7:0] cap);
		pbt_host_inst.scan(1'b1, 8, {24'h0, op}, d);
		`CHK("capture", cap, d[7:0])
	endtask

	task automatic dr(input int n, input logic [31:0] din);
		pbt_host_inst.scan(1'b0, n, din, d);
	endtask

	task automatic strobe(input logic [2:0] m);
		@(posedge clk_in);
		{sec_set, erase, uc_load} <= m;
		@(posedge clk_in);
		{sec_set, erase, uc_load} <= 3'b000;
		repeat (2) @(posedge clk_in);
		#1;
	endtask

	task automatic conclude();
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		conclude();
	end

	initial begin
		rst_in = 1'b1;
		prog_mode = 1'b0;
		{sec_set, erase, uc_load} = 3'b000;
		uc_val = 32'h12345678;
		fo = 9'h155;
		foe = 9'h1FF;
		pin_in = 3'h5;
		// Test clock must run while reset is held to reach its domain
		pbt_host_inst.reset_tap();
		@(posedge clk_in);
		rst_in <= 1'b0;
		pbt_host_inst.reset_tap();
		dr(32, 32'h0);
		`CHK("identification_register", pbt_pkg::ID_WORD, d)
		instr_scan(pbt_pkg::OP_SAMPLE, 8'h01);
		dr(21, {11'h0, pre});
		`CHK("sample", bsr(9'h155, 9'h1FF, 3'h5), d[20:0])
		instr_scan(pbt_pkg::OP_EXTEST, 8'h01);
		bs = bsr(pin_out, pin_oe_out, 3'h0);
		`CHK("extest", pre[20:3], bs[20:3])
		instr_scan(pbt_pkg::OP_CLAMP, 8'h01);
		bs = bsr(pin_out, pin_oe_out, 3'h0);
		`CHK("clamp", pre[20:3], bs[20:3])
		foreach (byp[j]) begin
			instr_scan(byp[j], 8'h01);
			dr(8, 32'hA5);
			`CHK("bypass", 8'h4A, d[7:0])
		end
		instr_scan(pbt_pkg::OP_HIGHZ, 8'h01);
		`CHK("highz", 9'h000, pin_oe_out)
		instr_scan(pbt_pkg::OP_USER_CODE_REGISTER, 8'h01);
		dr(32, 32'h0);
		`CHK("blank", 32'hFFFFFFFF, d)
		strobe(3'b001);
		instr_scan(pbt_pkg::OP_USER_CODE_REGISTER, 8'h01);
		dr(32, 32'h0);
		`CHK("user_code_register", 32'h12345678, d)
		@(posedge clk_in);
		prog_mode <= 1'b1;
		uc_val <= 32'hCAFE0001;
		strobe(3'b100);
		`CHK("read", 1'b0, read_allow)
		`CHK("program", 1'b0, prog_allow)
		`CHK("float", 9'h000, pin_oe_out)
		strobe(3'b001);
		instr_scan(pbt_pkg::OP_USER_CODE_REGISTER, 8'h19);
		dr(32, 32'h0);
		`CHK("locked", 32'h12345678, d)
		strobe(3'b010);
		`CHK("erased", 1'b1, read_allow)
		`CHK("program back", 1'b1, prog_allow)
		instr_scan(pbt_pkg::OP_USER_CODE_REGISTER, 8'h11);
		dr(32, 32'h0);
		`CHK("erase word", 32'hFFFFFFFF, d)
		@(posedge clk_in);
		prog_mode <= 1'b0;
		instr_scan(pbt_pkg::OP_RELOAD, 8'h01);
		repeat (80) @(posedge clk_in);
		`CHK("reload", 38, last_low)
		instr_scan(pbt_pkg::OP_IDENTIFICATION_REGISTER, 8'h01);
		dr(32, 32'h0);
		`CHK("identification_register scan", pbt_pkg::ID_WORD, d)
		strobe(3'b100);
		strobe(3'b110);
		`CHK("set wins", 1'b0, read_allow)
		conclude();
	end
endmodule // tb_top
